// >>> verilog/sdce_regs.svh
`ifndef SDCE_REGS_SVH
`define SDCE_REGS_SVH
// register indices on the plain port (8-bit data, 5-bit address)
`define SDCE_ADDR_LINE_FORMAT 5'h00
`define SDCE_ADDR_FEATURE 5'h01
`define SDCE_ADDR_IRQ_MASTER 5'h02
`define SDCE_ADDR_EXT_STATUS 5'h03
`define SDCE_ADDR_VECTOR_BASE 5'h04
`define SDCE_ADDR_MODE 5'h05
`define SDCE_ADDR_COMMAND 5'h06
`define SDCE_ADDR_TX_DATA 5'h07
`define SDCE_ADDR_PRIMARY 5'h08
`define SDCE_ADDR_SPECIAL 5'h09
`define SDCE_ADDR_VECTOR 5'h0A
`define SDCE_ADDR_FIFO_STAT 5'h0B
`define SDCE_ADDR_COUNT_LO 5'h0C
`define SDCE_ADDR_RX_DATA 5'h0D
`define SDCE_ADDR_IRQ_STAT 5'h0E
// line_format_ctrl fields
`define SDCE_LF_MARK_IDLE 3
`define SDCE_LF_ENC_LO 5
`define SDCE_LF_ENC_HI 6
// feature_enable_ctrl fields
`define SDCE_FE_AUTO_FLAG 0
`define SDCE_FE_AUTO_EOM 1
`define SDCE_FEATURE_RESET 8'h20
// interrupt_master_ctrl fields
`define SDCE_IM_VIS 0
`define SDCE_IM_NV 1
`define SDCE_IM_MIE 3
`define SDCE_IM_SOFT_ACK 5
// extended_status_ctrl fields
`define SDCE_XS_FIFO_EN 2
// mode register fields
`define SDCE_MD_SDLC 0
`define SDCE_MD_SYNC 1
`define SDCE_MD_TX_PLL 2
`define SDCE_MD_RX_PLL 3
// command codes
`define SDCE_CMD_RESET_TXIRQ 8'h01
`define SDCE_CMD_RESET_EOM 8'h02
`define SDCE_CMD_RESET_IUS 8'h03
`define SDCE_CMD_ABORT 8'h04
`define SDCE_CMD_IDLE_FLAG 8'h05
// status fifo geometry
`define SDCE_SFIFO_DEPTH 10
`define SDCE_SFIFO_WIDTH 19
`define SDCE_COUNT_WIDTH 14
// phase-lock divisors and receive crc tail length
`define SDCE_DIV_FM 6'd16
`define SDCE_DIV_NRZI 6'd32
`define SDCE_CRC_TAIL_BITS 2
`endif

// >>> verilog/sdce_pkg.sv
package sdce_pkg;
	typedef enum logic [2:0] {
		TX_IDLE, TX_DATA, TX_CRC, TX_FLAG, TX_ABORT
	} sdce_tx_type;
	typedef enum logic [1:0] {ENC_NRZ, ENC_NRZI, ENC_FM1, ENC_FM0} sdce_enc_type;
endpackage : sdce_pkg

// >>> verilog/sdce_pll_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdce_regs.svh"
module sdce_pll_div (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic pll_src_i,
	input wire logic fm_mode_i,
	output logic tx_tick_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic [5:0] cnt;
		logic tick;
	} sdce_div_type;
	sdce_div_type st_ff, nxt_st;
	always_comb begin
		logic [5:0] div;
		div = fm_mode_i ? `SDCE_DIV_FM : `SDCE_DIV_NRZI;
		nxt_st = st_ff;
		nxt_st.s1 = pll_src_i;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.tick = 1'b0;
		// counter output, not recovered clock: no jitter
		if (st_ff.s2 && !st_ff.s3) begin
			if (st_ff.cnt >= div - 6'd1) begin
				nxt_st.cnt = 6'h00;
				nxt_st.tick = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 6'd1;
			end
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign tx_tick_o = st_ff.tick;
endmodule : sdce_pll_div
`default_nettype wire

// >>> verilog/sdce_status_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdce_regs.svh"
module sdce_status_fifo #(
	parameter int DEPTH = `SDCE_SFIFO_DEPTH,
	parameter int WIDTH = `SDCE_SFIFO_WIDTH
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic push_i,
	input wire logic [WIDTH-1:0] push_data_i,
	input wire logic pop_i,
	output logic [WIDTH-1:0] head_o,
	output logic not_empty_o,
	output logic overflow_o
);
	typedef struct packed {
		logic [3:0] wr;
		logic [3:0] rd;
		logic [4:0] cnt;
		logic ovf;
	} sdce_sf_type;
	sdce_sf_type st_ff, nxt_st;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	function automatic logic [3:0] wrap_inc(input logic [3:0] p);
		wrap_inc = (p == 4'(DEPTH - 1)) ? 4'h0 : p + 4'h1;
	endfunction : wrap_inc
	logic do_push, do_pop;
	always_comb begin
		do_push = push_i && (st_ff.cnt != 5'(DEPTH));
		do_pop = pop_i && (st_ff.cnt != 5'h00);
		nxt_st = st_ff;
		if (!enable_i) begin
			nxt_st = '0; // pointers and overflow cleared while disabled
		end else begin
			if (push_i && !do_push)
				nxt_st.ovf = 1'b1;
			if (do_push)
				nxt_st.wr = wrap_inc(st_ff.wr);
			if (do_pop)
				nxt_st.rd = wrap_inc(st_ff.rd);
			nxt_st.cnt = st_ff.cnt + 5'(do_push) - 5'(do_pop);
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (enable_i && do_push)
			mem_ff[st_ff.wr] <= push_data_i;
	end
	assign head_o = mem_ff[st_ff.rd];
	assign not_empty_o = st_ff.cnt != 5'h00;
	assign overflow_o = st_ff.ovf;
endmodule : sdce_status_fifo
`default_nettype wire

// >>> verilog/sdce_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdce_regs.svh"
module sdce_channel (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [4:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic pll_src_i,
	input wire logic tx_bit_tick_i,
	input wire logic rx_bit_tick_i,
	input wire logic rx_bit_i,
	input wire logic rx_flag_i,
	input wire logic rx_abort_i,
	input wire logic [4:0] rx_frame_stat_i,
	input wire logic ext_status_i,
	input wire logic chain_enable_in_i,
	input wire logic irq_ack_in_i,
	output logic txd_o,
	output logic tx_clk_sel_pll_o,
	output logic tx_pll_tick_o,
	output logic rx_clk_sel_pll_o,
	output logic rx_byte_valid_o,
	output logic [7:0] rx_byte_o,
	output logic irq_n_o,
	output logic chain_enable_out_o
);
	typedef struct packed {
		logic [1:0] s_in;
		logic [1:0] s_flag;
		logic [1:0] s_ack;
		logic flag_prev;
		logic [7:0] line_format_ctrl;
		logic [7:0] feature_enable_ctrl;
		logic [7:0] interrupt_master_ctrl;
		logic [7:0] extended_status_ctrl;
		logic [7:0] vec_base;
		logic [7:0] mode;
		logic [7:0] rdata;
		logic [7:0] primary_status_view;
		logic [2:0] txstate;
		logic [7:0] tx_hold;
		logic tx_hold_full;
		logic [3:0] tx_bitcnt;
		logic [7:0] tx_shift;
		logic flag_sent;
		logic abort_req;
		logic idle_flag;
		logic crc_preset;
		logic end_of_message_latch;
		logic [1:0] tx_irq_pending;
		logic in_service_latch;
		logic [7:0] rx_shift;
		logic [2:0] rx_bitcnt;
		logic [1:0] tail;
		logic rx_valid;
		logic [7:0] rx_byte;
		logic [`SDCE_COUNT_WIDTH-1:0] byte_count;
	} sdce_st_type;
	sdce_st_type st_ff, nxt_st;
	logic sf_en, sf_push, sf_pop, sf_ne, sf_ovf;
	logic [`SDCE_SFIFO_WIDTH-1:0] sf_head, sf_data;
	logic pll_tick, fm_mode;
	sdce_pkg::sdce_enc_type enc;
	function automatic logic [7:0] rd_mux(input sdce_st_type s, input logic [4:0] a,
		input logic ne, input logic ovf, input logic en, input logic [18:0] head,
		input logic [4:0] bypass, input logic [7:0] vec);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`SDCE_ADDR_LINE_FORMAT: v = s.line_format_ctrl;
			`SDCE_ADDR_FEATURE: v = s.feature_enable_ctrl;
			`SDCE_ADDR_IRQ_MASTER: v = s.interrupt_master_ctrl;
			`SDCE_ADDR_EXT_STATUS: v = s.extended_status_ctrl;
			`SDCE_ADDR_VECTOR_BASE: v = s.vec_base;
			`SDCE_ADDR_MODE: v = s.mode;
			`SDCE_ADDR_PRIMARY: v = s.primary_status_view;
			// head entry when enabled and filled, else live status
			`SDCE_ADDR_SPECIAL: v = {3'h0, (en && ne) ? head[18:14] : bypass};
			`SDCE_ADDR_VECTOR: v = vec;
			`SDCE_ADDR_FIFO_STAT: v = {ovf, ne, en ? head[13:8] : 6'h00};
			`SDCE_ADDR_COUNT_LO: v = en ? head[7:0] : 8'h00;
			`SDCE_ADDR_RX_DATA: v = s.rx_byte;
			`SDCE_ADDR_IRQ_STAT: v = {5'h00, s.in_service_latch, s.tx_irq_pending};
			default: v = 8'h00;
		endcase
		rd_mux = v;
	endfunction : rd_mux
	assign enc = sdce_pkg::sdce_enc_type'(st_ff.line_format_ctrl[`SDCE_LF_ENC_HI:`SDCE_LF_ENC_LO]);
	assign fm_mode = enc == sdce_pkg::ENC_FM0 || enc == sdce_pkg::ENC_FM1;
	assign sf_en = st_ff.extended_status_ctrl[`SDCE_XS_FIFO_EN]
		&& st_ff.mode[`SDCE_MD_SDLC];
	sdce_pll_div u_div (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.pll_src_i(pll_src_i),
		.fm_mode_i(fm_mode),
		.tx_tick_o(pll_tick)
	);
	sdce_status_fifo #(
		.DEPTH(`SDCE_SFIFO_DEPTH),
		.WIDTH(`SDCE_SFIFO_WIDTH)
	) u_sfifo (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.enable_i(sf_en),
		.push_i(sf_push),
		.push_data_i(sf_data),
		.pop_i(sf_pop),
		.head_o(sf_head),
		.not_empty_o(sf_ne),
		.overflow_o(sf_ovf)
	);
	logic rx_edge_flag, soft_ack, any_pend, tx_adv, live_txd;
	logic [7:0] vector;
	always_comb begin
		nxt_st = st_ff;
		sf_push = 1'b0;
		sf_pop = 1'b0;
		sf_data = {rx_frame_stat_i, st_ff.byte_count};
		nxt_st.s_in = {st_ff.s_in[0], rx_bit_i};
		nxt_st.s_flag = {st_ff.s_flag[0], rx_flag_i};
		nxt_st.s_ack = {st_ff.s_ack[0], irq_ack_in_i};
		// edge taken from the second flop only; a level would push every cycle
		rx_edge_flag = st_ff.s_flag[1] && !st_ff.flag_prev;
		nxt_st.flag_prev = st_ff.s_flag[1];
		any_pend = |st_ff.tx_irq_pending;
		vector = st_ff.interrupt_master_ctrl[`SDCE_IM_VIS]
			? {st_ff.vec_base[7:4], any_pend ? 3'h1 : 3'h0, st_ff.vec_base[0]}
			: st_ff.vec_base;
		soft_ack = rd_i && addr_i == `SDCE_ADDR_VECTOR
			&& st_ff.interrupt_master_ctrl[`SDCE_IM_SOFT_ACK];
		nxt_st.rx_valid = 1'b0;
		// read data one cycle later
		nxt_st.rdata = rd_i ? rd_mux(st_ff, addr_i, sf_ne, sf_ovf, sf_en, sf_head,
			rx_frame_stat_i, vector) : 8'h00;
		if (rd_i && addr_i == `SDCE_ADDR_SPECIAL && sf_en && sf_ne)
			sf_pop = 1'b1;
		// snapshot frozen across the read cycle
		if (!rd_i || addr_i != `SDCE_ADDR_PRIMARY)
			nxt_st.primary_status_view = {ext_status_i, 4'h0, !st_ff.tx_hold_full,
				1'b0, sf_ne};
		if ((soft_ack || st_ff.s_ack[1]) && any_pend && chain_enable_in_i)
			nxt_st.in_service_latch = 1'b1;
		// transmitter
		tx_adv = tx_bit_tick_i;
		if (tx_adv) begin
			if (st_ff.tx_bitcnt != 4'h0) begin
				nxt_st.tx_bitcnt = st_ff.tx_bitcnt - 4'h1;
				nxt_st.tx_shift = {1'b1, st_ff.tx_shift[7:1]};
			end else begin
				unique case (sdce_pkg::sdce_tx_type'(st_ff.txstate))
					sdce_pkg::TX_IDLE: begin
						if (st_ff.tx_hold_full && (st_ff.flag_sent
							|| !st_ff.line_format_ctrl[`SDCE_LF_MARK_IDLE])) begin
							nxt_st.txstate = sdce_pkg::TX_DATA;
							nxt_st.tx_shift = st_ff.tx_hold;
							nxt_st.tx_hold_full = 1'b0;
							nxt_st.tx_bitcnt = 4'h7;
							nxt_st.tx_irq_pending[0] = 1'b1;
						end else if ((st_ff.tx_hold_full
							&& st_ff.feature_enable_ctrl[`SDCE_FE_AUTO_FLAG])
							|| st_ff.idle_flag
							|| !st_ff.line_format_ctrl[`SDCE_LF_MARK_IDLE]) begin
							nxt_st.txstate = sdce_pkg::TX_FLAG;
							nxt_st.tx_shift = 8'h7E;
							nxt_st.tx_bitcnt = 4'h7;
						end
					end
					sdce_pkg::TX_DATA: begin
						if (st_ff.abort_req) begin
							nxt_st.txstate = sdce_pkg::TX_ABORT;
							nxt_st.tx_shift = 8'hFE;
							nxt_st.tx_bitcnt = 4'h7;
						end else if (st_ff.tx_hold_full) begin
							nxt_st.tx_shift = st_ff.tx_hold;
							nxt_st.tx_hold_full = 1'b0;
							nxt_st.tx_bitcnt = 4'h7;
							nxt_st.tx_irq_pending[0] = 1'b1;
						end else begin
							// underrun: end of message
							nxt_st.txstate = sdce_pkg::TX_CRC;
							nxt_st.tx_shift = 8'h00;
							nxt_st.tx_bitcnt = 4'hF;
							if (!st_ff.end_of_message_latch)
								nxt_st.tx_irq_pending[1] = 1'b1;
							nxt_st.end_of_message_latch = 1'b1;
						end
					end
					sdce_pkg::TX_CRC: begin
						nxt_st.txstate = sdce_pkg::TX_FLAG;
						nxt_st.tx_shift = 8'h7E;
						nxt_st.tx_bitcnt = 4'h7;
					end
					sdce_pkg::TX_FLAG, sdce_pkg::TX_ABORT: begin
						nxt_st.flag_sent = st_ff.txstate == sdce_pkg::TX_FLAG;
						nxt_st.abort_req = 1'b0;
						nxt_st.txstate = sdce_pkg::TX_IDLE;
						if (st_ff.feature_enable_ctrl[`SDCE_FE_AUTO_EOM]) begin
							nxt_st.end_of_message_latch = 1'b0;
							nxt_st.crc_preset = 1'b1;
						end
					end
					default: nxt_st.txstate = sdce_pkg::TX_IDLE;
				endcase
			end
		end
		if (!st_ff.line_format_ctrl[`SDCE_LF_MARK_IDLE])
			nxt_st.flag_sent = 1'b0;
		// receiver
		if (rx_bit_tick_i) begin
			nxt_st.rx_shift = {st_ff.s_in[1], st_ff.rx_shift[7:1]};
			nxt_st.rx_bitcnt = st_ff.rx_bitcnt + 3'h1;
			if (st_ff.tail != 2'h0) begin
				nxt_st.tail = st_ff.tail - 2'h1;
				if (st_ff.tail == 2'h1) begin
					nxt_st.rx_valid = 1'b1;
					nxt_st.rx_byte = {st_ff.s_in[1], st_ff.rx_shift[7:1]};
					nxt_st.rx_bitcnt = 3'h0;
					// frame ends once the crc tail is in, so the tail byte is counted
					sf_push = sf_en;
					sf_data = {rx_frame_stat_i, st_ff.byte_count + 14'h1};
					nxt_st.byte_count = '0;
				end
			end else if (st_ff.rx_bitcnt == 3'h7) begin
				nxt_st.rx_valid = 1'b1;
				nxt_st.rx_byte = {st_ff.s_in[1], st_ff.rx_shift[7:1]};
				nxt_st.byte_count = st_ff.byte_count + 14'h1;
			end
		end
		if (rx_edge_flag && st_ff.tail == 2'h0) begin
			if (st_ff.mode[`SDCE_MD_SDLC]) begin
				nxt_st.tail = 2'(`SDCE_CRC_TAIL_BITS);
			end else begin
				nxt_st.rx_bitcnt = 3'h0;
				sf_push = sf_en;
				nxt_st.byte_count = '0;
			end
		end
		if (rx_abort_i) begin
			sf_push = sf_en;
			nxt_st.byte_count = '0;
		end
		// register writes
		if (wr_i) begin
			unique case (addr_i)
				`SDCE_ADDR_LINE_FORMAT: nxt_st.line_format_ctrl = wdata_i;
				`SDCE_ADDR_FEATURE: nxt_st.feature_enable_ctrl = wdata_i;
				`SDCE_ADDR_IRQ_MASTER: nxt_st.interrupt_master_ctrl = wdata_i;
				`SDCE_ADDR_EXT_STATUS: nxt_st.extended_status_ctrl = wdata_i;
				`SDCE_ADDR_VECTOR_BASE: nxt_st.vec_base = wdata_i;
				`SDCE_ADDR_MODE: nxt_st.mode = wdata_i;
				`SDCE_ADDR_TX_DATA: begin
					// accepted even while the current frame closes
					nxt_st.tx_hold = wdata_i;
					nxt_st.tx_hold_full = 1'b1;
				end
				`SDCE_ADDR_COMMAND: begin
					unique case (wdata_i)
						`SDCE_CMD_RESET_TXIRQ: begin
							// one pending source cleared per command
							if (st_ff.tx_irq_pending[0]
								&& !(tx_adv && nxt_st.tx_irq_pending[0] && st_ff.tx_bitcnt == 4'h0
								&& st_ff.txstate != sdce_pkg::TX_IDLE))
								nxt_st.tx_irq_pending[0] = 1'b0;
							else if (!(nxt_st.tx_irq_pending[1] && !st_ff.tx_irq_pending[1]))
								nxt_st.tx_irq_pending[1] = 1'b0;
						end
						`SDCE_CMD_RESET_EOM: begin
							nxt_st.end_of_message_latch = 1'b0;
							nxt_st.crc_preset = 1'b1;
						end
						`SDCE_CMD_RESET_IUS: nxt_st.in_service_latch = 1'b0;
						`SDCE_CMD_ABORT: nxt_st.abort_req = 1'b1;
						`SDCE_CMD_IDLE_FLAG: nxt_st.idle_flag = 1'b1;
						default: nxt_st.crc_preset = st_ff.crc_preset;
					endcase
				end
				default: nxt_st.rdata = nxt_st.rdata;
			endcase
		end
		if (st_ff.txstate == sdce_pkg::TX_DATA)
			nxt_st.crc_preset = 1'b0;
		if (!st_ff.line_format_ctrl[`SDCE_LF_MARK_IDLE])
			nxt_st.idle_flag = 1'b0;
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.feature_enable_ctrl <= `SDCE_FEATURE_RESET;
			st_ff.line_format_ctrl <= 8'h08;
			st_ff.tx_shift <= 8'hFF;
			st_ff.primary_status_view <= 8'h04;
		end else begin
			st_ff <= nxt_st;
		end
	end
	// mark idle in sdlc nrzi holds line high
	assign live_txd = (st_ff.txstate == sdce_pkg::TX_IDLE) ? 1'b1 : st_ff.tx_shift[0];
	assign txd_o = (st_ff.mode[`SDCE_MD_SDLC] && enc == sdce_pkg::ENC_NRZI
		&& st_ff.line_format_ctrl[`SDCE_LF_MARK_IDLE]
		&& st_ff.txstate == sdce_pkg::TX_IDLE) ? 1'b1 : live_txd;
	assign tx_clk_sel_pll_o = st_ff.mode[`SDCE_MD_TX_PLL];
	assign tx_pll_tick_o = st_ff.mode[`SDCE_MD_TX_PLL] && pll_tick;
	assign rx_clk_sel_pll_o = st_ff.mode[`SDCE_MD_RX_PLL];
	assign rx_byte_valid_o = st_ff.rx_valid;
	assign rx_byte_o = st_ff.rx_byte;
	assign rdata_o = st_ff.rdata;
	// in service releases irq and lowers chain
	assign irq_n_o = !(st_ff.interrupt_master_ctrl[`SDCE_IM_MIE] && any_pend
		&& !st_ff.in_service_latch && chain_enable_in_i);
	assign chain_enable_out_o = chain_enable_in_i && !st_ff.in_service_latch
		&& !(any_pend && st_ff.interrupt_master_ctrl[`SDCE_IM_MIE]);
endmodule : sdce_channel
`default_nettype wire

// >>> verif/sdce_channel_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sdce_channel_checker (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [4:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic txd_o,
	input wire logic tx_clk_sel_pll_o,
	input wire logic tx_pll_tick_o,
	input wire logic rx_clk_sel_pll_o,
	input wire logic irq_n_o,
	input wire logic chain_enable_out_o
);
	logic soft_ff, wq_v_ff;
	logic [4:0] wq_a_ff;
	logic [7:0] wq_d_ff;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// shadow of the last config write for read-back checks, plus the soft-ack bit for the soft-ack check
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			soft_ff <= 1'b0;
			wq_v_ff <= 1'b0;
		end else if (wr_i) begin
			wq_v_ff <= addr_i <= 5'h03;
			wq_a_ff <= addr_i;
			wq_d_ff <= wdata_i;
			if (addr_i == 5'h02) begin
				soft_ff <= wdata_i[5];
			end
		end
	end
	property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
	property p_unmapped; rd_i && addr_i > 5'h0E |=> rdata_o == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_readback; rd_i && wq_v_ff && addr_i == wq_a_ff |=> rdata_o == $past(wq_d_ff); endproperty
	a_readback: assert property (p_readback) else $error("config read-back differs");
	property p_tx_sel; wr_i && addr_i == 5'h05 |=> tx_clk_sel_pll_o == $past(wdata_i[2]); endproperty
	a_tx_sel: assert property (p_tx_sel) else $error("tx clock select wrong");
	property p_rx_sel; wr_i && addr_i == 5'h05 |=> rx_clk_sel_pll_o == $past(wdata_i[3]); endproperty
	a_rx_sel: assert property (p_rx_sel) else $error("rx clock select disturbed");
	property p_tick_gap; tx_pll_tick_o |=> !tx_pll_tick_o [*8]; endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("divided tick too close");
	property p_tick_gate; !tx_clk_sel_pll_o && !$past(tx_clk_sel_pll_o) |-> !tx_pll_tick_o; endproperty
	a_tick_gate: assert property (p_tick_gate) else $error("tick without selection");
	property p_soft_ack; rd_i && addr_i == 5'h0A && soft_ff && !irq_n_o |=> irq_n_o && !chain_enable_out_o; endproperty
	a_soft_ack: assert property (p_soft_ack) else $error("soft ack did not release irq");
	property p_reset_out; $fell(rst_i) |-> txd_o && irq_n_o && rdata_o == 8'h00; endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
	c_soft_ack: cover property (rd_i && addr_i == 5'h0A && soft_ff);
	c_tick: cover property (tx_pll_tick_o);
	c_fifo: cover property (rd_i && addr_i == 5'h0B);
endmodule : sdce_channel_checker
bind sdce_channel sdce_channel_checker u_chk (
	.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .txd_o,
	.tx_clk_sel_pll_o, .tx_pll_tick_o, .rx_clk_sel_pll_o, .irq_n_o, .chain_enable_out_o
);
`default_nettype wire

// >>> verif/sdce_remote_station.sv
`timescale 1ns/1ps
`default_nettype none
module sdce_remote_station (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [3:0] nbytes_i,
	input wire logic [7:0] byte_i,
	output logic busy_o,
	output logic pll_src_o,
	output logic tx_tick_o,
	output logic rx_tick_o,
	output logic rx_bit_o,
	output logic rx_flag_o
);
	logic [2:0] div_ff;
	logic [6:0] pos_ff;
	logic [6:0] last_ff;
	logic [7:0] byte_ff;
	always_ff @(posedge sys_clk_i) begin
		div_ff <= rst_i ? 3'h0 : div_ff + 3'h1;
		pll_src_o <= div_ff[1];
		tx_tick_o <= div_ff == 3'h7;
		// receive clock stands still between frames
		// only data steps are ticked, so the first step's stale bit is never taken
		rx_tick_o <= busy_o && div_ff == 3'h7 && pos_ff >= 7'h02 && pos_ff <= last_ff + 7'h01;
		if (rst_i) begin
			busy_o <= 1'b0;
			rx_flag_o <= 1'b0;
			rx_bit_o <= 1'b1;
		end else if (start_i && !busy_o) begin
			busy_o <= 1'b1;
			pos_ff <= 7'h00;
			byte_ff <= byte_i;
			last_ff <= {nbytes_i, 3'h0};
		end else if (busy_o && div_ff == 3'h3) begin
			// line moves mid-period, far from the tick, so the sync flops see it settled
			pos_ff <= pos_ff + 7'h01;
			// closing flag seen one bit before the last bit, as a receiver sees it
			rx_flag_o <= pos_ff + 7'h01 >= last_ff;
			rx_bit_o <= byte_ff[pos_ff[2:0] - 3'h1];
			if (pos_ff == last_ff + 7'h03) begin
				busy_o <= 1'b0;
				rx_flag_o <= 1'b0;
				rx_bit_o <= ~rx_bit_o;
			end
		end
	end
endmodule : sdce_remote_station
`default_nettype wire

// >>> verif/sdce_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdce_channel_tb_top;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] addr_i = 5'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic ext_status_i = 1'b0;
	logic [4:0] rx_frame_stat_i = 5'h15;
	logic start = 1'b0;
	logic [3:0] nbytes = 4'h3;
	logic [7:0] last_byte = 8'h00;
	logic [7:0] rdata_o, rx_byte_o, d;
	logic txd_o, tx_clk_sel_pll_o, tx_pll_tick_o, rx_clk_sel_pll_o, rx_byte_valid_o;
	logic irq_n_o, chain_enable_out_o, busy, pll_src, tx_tick, rx_tick, rx_bit, rx_flag;
	logic [7:0] lf_tab [3] = '{8'h60, 8'h40, 8'h20};
	int dv_tab [3] = '{16, 16, 32};
	int n_mismatch = 0;
	int n_compared = 0;
	int nrx = 0;
	int c, z, k;
	always #25 sys_clk_i = ~sys_clk_i;
	sdce_channel dut (
		.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.pll_src_i(pll_src), .tx_bit_tick_i(tx_tick), .rx_bit_tick_i(rx_tick),
		.rx_bit_i(rx_bit), .rx_flag_i(rx_flag), .rx_abort_i(1'b0), .rx_frame_stat_i,
		.ext_status_i, .chain_enable_in_i(1'b1), .irq_ack_in_i(1'b0), .txd_o,
		.tx_clk_sel_pll_o, .tx_pll_tick_o, .rx_clk_sel_pll_o, .rx_byte_valid_o,
		.rx_byte_o, .irq_n_o, .chain_enable_out_o
	);
	sdce_remote_station u_remote (
		.sys_clk_i, .rst_i, .start_i(start), .nbytes_i(nbytes), .byte_i(8'hC3),
		.busy_o(busy), .pll_src_o(pll_src), .tx_tick_o(tx_tick), .rx_tick_o(rx_tick),
		.rx_bit_o(rx_bit), .rx_flag_o(rx_flag)
	);
	always @(posedge sys_clk_i) begin
		if (rx_byte_valid_o === 1'b1) begin
			last_byte <= rx_byte_o;
			nrx <= nrx + 1;
		end
	end
	task automatic results;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	task automatic fail;
		n_mismatch++;
		results();
	endtask : fail
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [4:0] a);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic poll(input logic [4:0] a, input logic [7:0] m);
		d = 8'h00;
		for (int i = 0; (d & m) == 8'h00; i++) begin
			if (i > 400) fail();
			rd(a);
		end
	endtask : poll
	// first two intervals may straddle a divisor change, so only the third counts
	task automatic meas(output int cnt);
		for (int i = 0; i < 3; i++) begin
			cnt = 0;
			do begin
				@(posedge sys_clk_i);
				cnt++;
				if (cnt > 500) fail();
			end while (tx_pll_tick_o !== 1'b1);
		end
	endtask : meas
	task automatic scan(output int zc);
		zc = 0;
		repeat (400) @(posedge sys_clk_i);
		repeat (128) begin
			@(posedge sys_clk_i);
			if (txd_o !== 1'b1) zc++;
		end
	endtask : scan
	task automatic frame(input logic [3:0] n);
		@(posedge sys_clk_i);
		nrx = 0;
		start <= 1'b1;
		nbytes <= n;
		@(posedge sys_clk_i);
		start <= 1'b0;
		#1;
		for (int i = 0; busy === 1'b1; i++) begin
			if (i > 2000) fail();
			@(posedge sys_clk_i);
		end
		repeat (40) @(posedge sys_clk_i);
	endtask : frame
	initial begin
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rd(5'h00);
		chk(d, 8'h08);
		rd(5'h01);
		chk(d, 8'h20);
		rd(5'h1F);
		chk(d, 8'h00);
		wr(5'h05, 8'h04);
		for (k = 0; k < 3; k++) begin
			wr(5'h00, lf_tab[k]);
			meas(c);
			chk(c, dv_tab[k] * 4);
		end
		wr(5'h05, 8'h08);
		chk(rx_clk_sel_pll_o, 1'b1);
		chk(tx_clk_sel_pll_o, 1'b0);
		rd(5'h08);
		chk(d[7], 1'b0);
		@(posedge sys_clk_i) ext_status_i <= 1'b1;
		rd(5'h08);
		chk(d[7], 1'b1);
		wr(5'h05, 8'h01);
		wr(5'h04, 8'hA4);
		wr(5'h01, 8'h23);
		wr(5'h00, 8'h28);
		rd(5'h00);
		chk(d, 8'h28);
		wr(5'h07, 8'h5A);
		poll(5'h0E, 8'h02);
		chk(d[1:0], 2'b11);
		wr(5'h02, 8'h2A);
		chk(irq_n_o, 1'b0);
		rd(5'h0A);
		chk(d, 8'hA4);
		chk(irq_n_o, 1'b1);
		chk(chain_enable_out_o, 1'b0);
		rd(5'h0E);
		chk(d[2], 1'b1);
		wr(5'h06, 8'h03);
		wr(5'h02, 8'h2B);
		rd(5'h0A);
		chk(d, 8'hA2);
		wr(5'h06, 8'h03);
		wr(5'h06, 8'h01);
		rd(5'h0E);
		chk(d[1] ^ d[0], 1'b1);
		wr(5'h06, 8'h01);
		rd(5'h0E);
		chk(d[1:0], 2'b00);
		scan(z);
		chk(z, 0);
		wr(5'h07, 8'h5A);
		wr(5'h06, 8'h04);
		scan(z);
		chk(z, 0);
		wr(5'h00, 8'h20);
		scan(z);
		chk(z == 0, 1'b0);
		wr(5'h00, 8'h28);
		scan(z);
		chk(z, 0);
		wr(5'h00, 8'h08);
		wr(5'h03, 8'h04);
		rd(5'h03);
		chk(d, 8'h04);
		frame(4'h3);
		chk(nrx, 3);
		chk(last_byte, 8'hC3);
		rd(5'h0B);
		chk(d[7:6], 2'b01);
		rd(5'h0C);
		chk(d, 8'h03);
		rd(5'h09);
		chk(d[4:0], 5'h15);
		rd(5'h0B);
		chk(d[6], 1'b0);
		frame(4'h2);
		rd(5'h0B);
		rd(5'h0C);
		chk(d, 8'h02);
		rd(5'h09);
		for (k = 0; k < 11; k++) frame(4'h1);
		rd(5'h0B);
		chk(d[7:6], 2'b11);
		wr(5'h03, 8'h00);
		frame(4'h1);
		rd(5'h0B);
		chk(d[7:6], 2'b00);
		wr(5'h05, 8'h02);
		frame(4'h3);
		chk(nrx, 2);
		results();
	end
endmodule : sdce_channel_tb_top
`default_nettype wire
